// file: radio_config_spi_slave.sv
// radio serial configuration port: slave end with config registers and receive fifo
//
// Operation
// - all bytes shift most significant bit first
// - master opens with rw, burst, address header
// - master holds select low whole transfer
// - select release aborts unfinished byte transfer
// - master waits for data output low
// - drive data output low when oscillator runs
// - slave only, also serves receive data
// - provide 64-byte receive fifo
// - registers reset to defaults; master rewrites
// - 10 MHz needs 100 ns byte gaps
// - gapless single access at 9 MHz max
// - unwatched wakeup waits 150 us
// - status byte returned on every header/write
// - burst address counter steps per byte
// - 0x30-0x3D burst reads status, else strobe
// - burst one direction, ended by select
//
// Decided for this implementation: the address map and register access over AHB-Lite.
module radio_config_spi_slave #(
  parameter int RX_DEPTH = radio_spi_pkg::RX_FIFO_BYTES
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  spi_link_if.device      link,
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  output logic            rx_ready_o,
  input  wire logic       sleep_i,
  input  wire logic       osc_off_i,
  input  wire logic [2:0] radio_state_i,
  output logic            cfg_wr_o,
  output logic [5:0]      cfg_addr_o,
  output logic [7:0]      cfg_data_o,
  output logic            strobe_o,
  output logic [5:0]      strobe_addr_o
);
  localparam int RAW = $clog2(RX_DEPTH);

  // ----------
  // helpers
  // ----------
  // status and strobe space shares one address window
  function automatic logic in_stat(input logic [5:0] a);
    in_stat = (a >= radio_spi_pkg::STAT_FIRST) && (a <= radio_spi_pkg::STAT_LAST);
  endfunction

  // ----------
  // pin synchronisers
  // ----------
  logic sclk_s1;
  logic sclk_s2;
  logic sclk_s3;
  logic sel_s1;
  logic sel_s2;
  logic mosi_s1;
  logic mosi_s2;

  // sclk and data pass the same two stages so their alignment holds
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sclk_s1 <= 1'h0;
      sclk_s2 <= 1'h0;
      sclk_s3 <= 1'h0;
      sel_s1  <= 1'h0;
      sel_s2  <= 1'h0;
      mosi_s1 <= 1'h0;
      mosi_s2 <= 1'h0;
    end
    else
    begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      sel_s1  <= ~link.port_select_low;
      sel_s2  <= sel_s1;
      mosi_s1 <= link.mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  logic sel;
  logic rise;
  logic fall;

  assign sel  = sel_s2;
  assign rise = sel && sclk_s2 && !sclk_s3;
  assign fall = sel && !sclk_s2 && sclk_s3;

  // ----------
  // receive fifo, 64 bytes deep
  // ----------
  logic [7:0]   rx_mem [RX_DEPTH];
  logic [RAW:0] rx_wp;
  logic [RAW:0] rx_rp;
  logic [RAW:0] rx_count;
  logic         rx_pop;
  logic         rx_push;

  assign rx_count   = rx_wp - rx_rp;
  assign rx_ready_o = rx_count != RX_DEPTH[RAW:0];
  assign rx_push    = rx_valid_i && rx_ready_o;

  always_ff @(posedge mclk_i)
  begin
    if (rx_push)
      rx_mem[rx_wp[RAW-1:0]] <= rx_data_i;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rx_wp <= '0;
      rx_rp <= '0;
    end
    else
    begin
      if (rx_push)
        rx_wp <= rx_wp + 1'h1;
      if (rx_pop)
        rx_rp <= rx_rp + 1'h1;
    end
  end

  // ----------
  // chip status byte
  // ----------
  logic       ready_low;
  logic [3:0] avail;
  logic [7:0] status_byte;

  // oscillator_ready_low: high while asleep or with the oscillator off
  assign ready_low   = sleep_i || osc_off_i;
  assign avail       = (rx_count >= (RAW + 1)'(15)) ? radio_spi_pkg::AVAIL_SAT
                                                    : rx_count[3:0];
  assign status_byte = {ready_low, radio_state_i, avail};

  // ----------
  // bit and byte framing
  // ----------
  logic [2:0] bit_cnt;
  logic [6:0] sh;
  logic       started;
  logic       done;
  logic [7:0] byte_in;

  assign done    = rise && (bit_cnt == 3'h7);
  assign byte_in = {sh, mosi_s2};

  // any partial byte is dropped when select goes away
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bit_cnt <= 3'h0;
      sh      <= 7'h00;
      started <= 1'h0;
    end
    else if (!sel)
    begin
      bit_cnt <= 3'h0;
      started <= 1'h0;
    end
    else if (rise)
    begin
      sh      <= byte_in[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      started <= 1'h1;
    end
  end

  // ----------
  // header decode and burst address counter
  // ----------
  logic       in_data;
  logic       rw;
  logic       burst;
  logic [5:0] addr;
  logic [5:0] next_addr;

  // the fifo address does not move so a burst drains the fifo
  assign next_addr = (burst && addr != radio_spi_pkg::FIFO_ADDR) ? addr + 6'h01 : addr;

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      in_data <= 1'h0;
      rw      <= 1'h0;
      burst   <= 1'h0;
      addr    <= 6'h00;
    end
    else if (!sel)
      in_data <= 1'h0;
    else if (done && !in_data)
    begin
      in_data <= 1'h1;
      rw      <= byte_in[radio_spi_pkg::HDR_RW_BIT];
      burst   <= byte_in[radio_spi_pkg::HDR_BURST_BIT];
      addr    <= byte_in[5:0];
    end
    else if (done)
      addr <= next_addr;
  end

  // ----------
  // configuration registers, writes and strobes
  // ----------
  logic [7:0] cfg [64];
  logic       wr_hit;
  logic       strobe_hit;

  assign wr_hit     = done && in_data && !rw && (addr <= radio_spi_pkg::CFG_LAST);
  assign strobe_hit = done && !in_data && !byte_in[radio_spi_pkg::HDR_BURST_BIT]
                      && in_stat(byte_in[5:0]);

  // every register returns to its default under reset
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < 64; i++)
        cfg[i] <= radio_spi_pkg::CFG_RESET;
    end
    else if (wr_hit)
      cfg[addr] <= byte_in;
  end

  // one-cycle notices to the radio core
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cfg_wr_o      <= 1'h0;
      cfg_addr_o    <= 6'h00;
      cfg_data_o    <= 8'h00;
      strobe_o      <= 1'h0;
      strobe_addr_o <= 6'h00;
    end
    else
    begin
      cfg_wr_o <= wr_hit;
      strobe_o <= strobe_hit;
      if (wr_hit)
      begin
        cfg_addr_o <= addr;
        cfg_data_o <= byte_in;
      end
      if (strobe_hit)
        strobe_addr_o <= byte_in[5:0];
    end
  end

  // ----------
  // read data selection
  // ----------
  logic       rd_next;
  logic [5:0] rd_addr;
  logic       rd_burst;
  logic [7:0] rd_byte;

  // after the header the header's own fields choose the next byte
  assign rd_next  = in_data ? rw : byte_in[radio_spi_pkg::HDR_RW_BIT];
  assign rd_addr  = in_data ? next_addr : byte_in[5:0];
  assign rd_burst = in_data ? burst : byte_in[radio_spi_pkg::HDR_BURST_BIT];
  assign rx_pop   = done && rd_next && rd_addr == radio_spi_pkg::FIFO_ADDR
                    && rx_count != '0;

  always_comb
  begin
    rd_byte = 8'h00;
    if (rd_addr <= radio_spi_pkg::CFG_LAST)
      rd_byte = cfg[rd_addr];
    else if (rd_addr == radio_spi_pkg::FIFO_ADDR)
      rd_byte = rx_mem[rx_rp[RAW-1:0]];
    else if (rd_burst && rd_addr == radio_spi_pkg::RXCOUNT_ADDR)
      rd_byte = 8'(rx_count);
    else if (rd_burst && in_stat(rd_addr))
      rd_byte = {5'h00, radio_state_i};
  end

  // ----------
  // output shifter
  // ----------
  logic [7:0] tx;
  logic       miso_q;
  logic       oe_q;

  // writes and headers answer with status, reads with register data
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      tx <= 8'h00;
    else if (!started)
      tx <= status_byte;
    else if (done)
      tx <= rd_next ? rd_byte : status_byte;
  end

  // before the first edge the line shows oscillator readiness live
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      miso_q <= 1'h1;
      oe_q   <= 1'h0;
    end
    else
    begin
      oe_q <= sel;
      if (!sel)
        miso_q <= 1'h1;
      else if (!started)
        miso_q <= ready_low;
      else if (fall)
        miso_q <= tx[3'h7 - bit_cnt];
    end
  end

  assign link.miso    = miso_q;
  assign link.miso_oe = oe_q;
endmodule

// file: radio_spi_pkg.sv
// shared constants for the radio configuration serial port and its controller
package radio_spi_pkg;

  // ----------
  // header byte and device address map
  // ----------
  localparam int         HDR_RW_BIT    = 7;
  localparam int         HDR_BURST_BIT = 6;
  localparam logic [5:0] CFG_LAST      = 6'h2e;
  localparam logic [5:0] STAT_FIRST    = 6'h30;
  localparam logic [5:0] STAT_LAST     = 6'h3d;
  localparam logic [5:0] RXCOUNT_ADDR  = 6'h3b;
  localparam logic [5:0] FIFO_ADDR     = 6'h3f;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam int         RX_FIFO_BYTES = 64;
  localparam logic [3:0] AVAIL_SAT     = 4'hf;

  // ----------
  // timing
  // ----------
  localparam int MCLK_NS       = 20;
  localparam int GAP_NS        = 100;
  localparam int GAP_CYC       = (GAP_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int SCLK_HALF_CYC = 8;

  // ----------
  // controller register map (byte addresses on the system bus)
  // ----------
  localparam logic [7:0] CTRL_ADDR     = 8'h00;
  localparam logic [7:0] TXDATA_ADDR   = 8'h04;
  localparam logic [7:0] RXDATA_ADDR   = 8'h08;
  localparam logic [7:0] STATUS_ADDR   = 8'h0c;
  localparam int         CTRL_CNT_LSB  = 8;
  localparam int         CTRL_GO_BIT   = 16;
  localparam int         ST_BUSY_BIT   = 0;
  localparam int         ST_TXFULL_BIT = 1;
  localparam int         ST_RXVAL_BIT  = 2;
  localparam int         ST_CHIP_LSB   = 8;

  typedef enum logic [2:0] {
    M_IDLE  = 3'h0,
    M_SEL   = 3'h1,
    M_SHIFT = 3'h2,
    M_GAP   = 3'h3,
    M_END   = 3'h4
  } master_state_e;

endpackage

// file: spi_link_if.sv
// four-wire serial link between the controller and the radio port
interface spi_link_if;
  logic port_select_low;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;

  // data output floats while deselected; the board pulls it high
  assign miso_line = miso_oe ? miso : 1'h1;

  modport device (input port_select_low, input sclk, input mosi, output miso, output miso_oe);
  modport host (output port_select_low, output sclk, output mosi, input miso_line);
endinterface

// file: byte_fifo.sv
// synchronous fifo with valid/ready on both sides
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp;
  logic [AW:0]      rp;
  logic             push;
  logic             pop;

  // ----------
  // flags: pointers carry an extra wrap bit so full and empty differ
  // ----------
  assign in_ready_o  = (wp[AW] == rp[AW]) || (wp[AW-1:0] != rp[AW-1:0]);
  assign out_valid_o = wp != rp;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rp[AW-1:0]];

  // storage
  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem[wp[AW-1:0]] <= in_data_i;
  end

  // pointers
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      if (push)
        wp <= wp + 1'h1;
      if (pop)
        rp <= rp + 1'h1;
    end
  end
endmodule

// file: radio_config_spi_master.sv
// controller end: system bus registers driving the serial link as master
module radio_config_spi_master #(
  parameter int HALF_CYC = radio_spi_pkg::SCLK_HALF_CYC,
  parameter int GAP_CYC  = radio_spi_pkg::GAP_CYC,
  parameter int BUF_W    = 8,
  parameter int BUF_D    = 16
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  spi_link_if.host         link
);
  // ----------
  // bus slave
  // ----------
  logic       ph_wr;
  logic [7:0] ph_addr;
  logic       acc;
  logic       tx_in_valid;
  logic       tx_in_ready;
  logic       tx_out_valid;
  logic       tx_out_ready;
  logic [7:0] tx_out_data;
  logic       rx_in_ready;
  logic       rx_out_valid;
  logic       rx_out_ready;
  logic [7:0] rx_out_data;
  logic       busy;
  logic [7:0] hdr;
  logic [5:0] cnt;
  logic       go;
  logic [7:0] chip_stat;

  assign acc          = hsel_i && hready_i && htrans_i[1] && hsize_i == 3'h2;
  assign tx_in_valid  = ph_wr && ph_addr == radio_spi_pkg::TXDATA_ADDR;
  assign hreadyout_o  = !(tx_in_valid && !tx_in_ready); // stall while tx buffer full
  assign hresp_o      = 1'h0;
  assign rx_out_ready = acc && !hwrite_i && haddr_i[7:0] == radio_spi_pkg::RXDATA_ADDR;

  // address phase capture, read data set up for the data phase
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ph_wr    <= 1'h0;
      ph_addr  <= 8'h00;
      hrdata_o <= 32'h0;
    end
    else if (hreadyout_o)
    begin
      ph_wr   <= acc && hwrite_i;
      ph_addr <= haddr_i[7:0];
      case (haddr_i[7:0])
        radio_spi_pkg::CTRL_ADDR:   hrdata_o <= {18'h0, cnt, hdr};
        radio_spi_pkg::RXDATA_ADDR: hrdata_o <= rx_out_valid ? {24'h0, rx_out_data} : 32'h0;
        radio_spi_pkg::STATUS_ADDR: hrdata_o <= {16'h0, chip_stat, 5'h00, rx_out_valid,
                                                 !tx_in_ready, busy};
        default:                    hrdata_o <= 32'h0;
      endcase
    end
  end

  // control register: header byte, data byte count, start
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hdr <= 8'h00;
      cnt <= 6'h00;
      go  <= 1'h0;
    end
    else
    begin
      go <= 1'h0;
      if (ph_wr && ph_addr == radio_spi_pkg::CTRL_ADDR && !busy)
      begin
        hdr <= hwdata_i[7:0];
        cnt <= hwdata_i[radio_spi_pkg::CTRL_CNT_LSB +: 6];
        go  <= hwdata_i[radio_spi_pkg::CTRL_GO_BIT];
      end
    end
  end

  // ----------
  // data buffers
  // ----------
  logic       rx_push;
  logic [7:0] rx_byte;

  byte_fifo #(.WIDTH(BUF_W), .DEPTH(BUF_D)) u_tx_fifo (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (tx_in_valid),
    .in_ready_o  (tx_in_ready),
    .in_data_i   (hwdata_i[7:0]),
    .out_valid_o (tx_out_valid),
    .out_ready_i (tx_out_ready),
    .out_data_o  (tx_out_data)
  );

  byte_fifo #(.WIDTH(BUF_W), .DEPTH(BUF_D)) u_rx_fifo (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (rx_push),
    .in_ready_o  (rx_in_ready),
    .in_data_i   (rx_byte),
    .out_valid_o (rx_out_valid),
    .out_ready_i (rx_out_ready),
    .out_data_o  (rx_out_data)
  );

  // ----------
  // link engine
  // ----------
  radio_spi_pkg::master_state_e st;
  logic       miso_s1;
  logic       miso_s2;
  logic [7:0] div;
  logic [2:0] bit_cnt;
  logic [5:0] left;
  logic       is_hdr;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic       rw;
  logic       gap_ok;

  assign busy         = st != radio_spi_pkg::M_IDLE;
  assign rw           = hdr[radio_spi_pkg::HDR_RW_BIT];
  // next byte waits for the gap, for buffer room or for write data
  assign gap_ok       = div >= 8'(GAP_CYC - 1) && !rx_push && (rw || tx_out_valid);
  assign tx_out_ready = st == radio_spi_pkg::M_GAP && gap_ok && !rw;

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      miso_s1 <= 1'h1;
      miso_s2 <= 1'h1;
    end
    else
    begin
      miso_s1 <= link.miso_line;
      miso_s2 <= miso_s1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st                   <= radio_spi_pkg::M_IDLE;
      link.port_select_low <= 1'h1;
      link.sclk            <= 1'h0;
      link.mosi            <= 1'h0;
      div <= 8'h00; bit_cnt <= 3'h0; left <= 6'h00; is_hdr <= 1'h0;
      tx_sh <= 8'h00; rx_sh <= 8'h00; rx_push <= 1'h0; rx_byte <= 8'h00;
      chip_stat <= 8'h00;
    end
    else
    begin
      if (rx_push && rx_in_ready)
        rx_push <= 1'h0;
      case (st)
        radio_spi_pkg::M_IDLE:
          if (go)
          begin
            link.port_select_low <= 1'h0;
            left <= cnt;
            st   <= radio_spi_pkg::M_SEL;
          end
        // the line may still show the last frame's low for a few cycles
        radio_spi_pkg::M_SEL:
          if (!miso_s2 && div >= 8'(HALF_CYC - 1))
          begin
            tx_sh     <= hdr;
            link.mosi <= hdr[7];
            is_hdr    <= 1'h1;
            div       <= 8'h00;
            st        <= radio_spi_pkg::M_SHIFT;
          end
          else
            div <= div + 8'h01;
        radio_spi_pkg::M_SHIFT:
          if (div == 8'(HALF_CYC - 1))
          begin
            div       <= 8'h00;
            link.sclk <= !link.sclk;
            if (!link.sclk)
              rx_sh <= {rx_sh[6:0], miso_s2};
            else if (bit_cnt != 3'h7)
            begin
              bit_cnt   <= bit_cnt + 3'h1;
              tx_sh     <= {tx_sh[6:0], 1'h0};
              link.mosi <= tx_sh[6];
            end
            else
            begin
              bit_cnt <= 3'h0;
              is_hdr  <= 1'h0;
              if (is_hdr)
                chip_stat <= rx_sh;
              else if (rw)
              begin
                rx_push <= 1'h1;
                rx_byte <= rx_sh;
              end
              st <= (left == 6'h00) ? radio_spi_pkg::M_END : radio_spi_pkg::M_GAP;
            end
          end
          else
            div <= div + 8'h01;
        radio_spi_pkg::M_GAP:
          if (gap_ok)
          begin
            tx_sh     <= rw ? 8'h00 : tx_out_data;
            link.mosi <= rw ? 1'h0 : tx_out_data[7];
            left      <= left - 6'h01;
            div       <= 8'h00;
            st        <= radio_spi_pkg::M_SHIFT;
          end
          else
            div <= div + 8'h01;
        radio_spi_pkg::M_END:
          if (div >= 8'(HALF_CYC - 1) && !rx_push)
          begin
            link.port_select_low <= 1'h1;
            div <= 8'h00;
            st  <= radio_spi_pkg::M_IDLE;
          end
          else
            div <= div + 8'h01;
        default:
          st <= radio_spi_pkg::M_IDLE;
      endcase
    end
  end
endmodule

// file: radio_link_properties.sv
// concurrent checks on the serial link between controller and radio port
module radio_link_properties #(
  parameter int HALF_CYC = radio_spi_pkg::SCLK_HALF_CYC
) (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  input  wire logic port_select_low,
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // ----------
  // helper counters
  // ----------
  logic [7:0] rises;
  logic [7:0] hi;

  // clock rises since select fell; zero marks the ready bit
  always_ff @(posedge mclk_i or negedge rst_b_i)
    if (!rst_b_i) rises <= 8'h00;
    else if (port_select_low) rises <= 8'h00;
    else if ($rose(sclk)) rises <= rises + 8'h01;

  // length of the current clock high phase
  always_ff @(posedge mclk_i or negedge rst_b_i)
    if (!rst_b_i) hi <= 8'h00;
    else hi <= sclk ? hi + 8'h01 : 8'h00;

  // ----------
  // properties
  // ----------
  a_oe_on_select: assert property ($fell(port_select_low) |-> ##[1:5] miso_oe)
    else $error("data output not driven after select");
  a_oe_off_idle: assert property (port_select_low [*6] |-> !miso_oe)
    else $error("data output driven while deselected");
  a_ready_first_rise: assert property ($rose(sclk) && rises == 8'h00 |-> !miso)
    else $error("ready bit high at first clock rise");
  a_miso_hold: assert property ($rose(sclk) |=> $stable(miso) [*3])
    else $error("data output moved while clock high");
  a_mosi_hold: assert property ($rose(sclk) |=> $stable(mosi) [*3])
    else $error("data input moved while clock high");
  a_clk_in_select: assert property (sclk |-> !port_select_low)
    else $error("clock high while deselected");
  a_high_time: assert property ($fell(sclk) |-> hi == 8'(HALF_CYC))
    else $error("clock high phase has wrong length");
  a_whole_bytes: assert property ($rose(port_select_low) |-> rises[2:0] == 3'h0)
    else $error("frame ended inside a byte");
endmodule

// file: radio_config_spi_slave_tb_top.sv
// self-checking bench: controller and radio port joined over the serial link
module radio_config_spi_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        rx_valid = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic        rx_ready;
  logic        sleep = 1'b0;
  logic        osc_off = 1'b0;
  logic [2:0]  state = 3'h0;
  logic        cfg_wr, strobe, cfg_wr_b;
  logic [5:0]  cfg_addr, strobe_addr;
  logic [7:0]  cfg_data, sh, b;
  logic [31:0] seed = 32'hb900ae97;
  logic [31:0] st;
  logic [7:0]  wd[16];
  logic [13:0] cq[$];
  logic [5:0]  sq[$];
  logic [7:0]  rq[$];
  int          so[3] = '{0, 7, 13};
  int          fail_count = 0;
  int          checks_done = 0;
  int          nb = 0;
  spi_link_if lnk();
  spi_link_if lnk2();

  always #10 mclk_i = ~mclk_i;

  radio_config_spi_master u_radio_config_spi_master (.mclk_i, .rst_b_i, .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hready_i(hreadyout), .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
    .hresp_o(), .link(lnk.host));
  radio_config_spi_slave u_radio_config_spi_slave (.mclk_i, .rst_b_i, .link(lnk.device),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready), .sleep_i(sleep),
    .osc_off_i(osc_off), .radio_state_i(state), .cfg_wr_o(cfg_wr), .cfg_addr_o(cfg_addr),
    .cfg_data_o(cfg_data), .strobe_o(strobe), .strobe_addr_o(strobe_addr));
  // spare port driven by hand so that select can drop mid-byte
  radio_config_spi_slave u_radio_config_spi_slave_b (.mclk_i, .rst_b_i, .link(lnk2.device),
    .rx_valid_i(1'b0), .rx_data_i(8'h00), .rx_ready_o(), .sleep_i(sleep),
    .osc_off_i(osc_off), .radio_state_i(state), .cfg_wr_o(cfg_wr_b), .cfg_addr_o(),
    .cfg_data_o(), .strobe_o(), .strobe_addr_o());
  radio_link_properties u_radio_link_properties (.mclk_i, .rst_b_i,
    .port_select_low(lnk.port_select_low), .sclk(lnk.sclk), .mosi(lnk.mosi),
    .miso(lnk.miso), .miso_oe(lnk.miso_oe));

  // record the port's write and strobe pulses, and the header on the wire
  always @(posedge mclk_i)
  begin
    if (cfg_wr === 1'b1) cq.push_back({cfg_addr, cfg_data});
    if (strobe === 1'b1) sq.push_back(strobe_addr);
    if (cfg_wr_b === 1'b1) nb++;
  end
  always @(posedge lnk.sclk) sh <= {sh[6:0], lnk.mosi};

  // ----------
  // helpers
  // ----------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // status byte expected for a given fill level; count saturates at 15
  function logic [7:0] stat(input logic [2:0] s, input int n);
    return {1'b0, s, (n > 15) ? 4'hf : 4'(n)};
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      $display("unexpected %s: expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask
  // one single transfer; read data lands in st
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge mclk_i iff hreadyout === 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk_i iff hreadyout === 1'b1);
    st = hrdata;
  endtask
  task run(input logic [7:0] h, input logic [5:0] n);
    ahb(1'b1, radio_spi_pkg::CTRL_ADDR, {15'h0, 1'b1, 2'h0, n, h});
    do
      ahb(1'b0, radio_spi_pkg::STATUS_ADDR, 32'h0);
    while (st[radio_spi_pkg::ST_BUSY_BIT] !== 1'b0);
  endtask
  task rd();
    ahb(1'b0, radio_spi_pkg::RXDATA_ADDR, 32'h0);
  endtask
  // write 0x05 <- 0xa5 on the spare port, releasing select after n bits
  task xfer(input int n);
    lnk2.port_select_low <= 1'b0;
    @(posedge mclk_i iff lnk2.miso_line === 1'b0);
    for (int i = 15; i >= 16 - n; i--)
    begin
      lnk2.mosi <= 1'(16'h05a5 >> i);
      repeat (4) @(posedge mclk_i);
      lnk2.sclk <= 1'b1;
      repeat (4) @(posedge mclk_i);
      lnk2.sclk <= 1'b0;
    end
    repeat (4) @(posedge mclk_i);
    lnk2.port_select_low <= 1'b1;
    repeat (20) @(posedge mclk_i);
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------
  // main sequence
  // ----------
  initial
  begin
    lnk2.port_select_low = 1'b1;
    lnk2.sclk = 1'b0;
    lnk2.mosi = 1'b0;
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    ahb(1'b0, radio_spi_pkg::STATUS_ADDR, 32'h0);
    chk("status after reset", 32'h0, {29'h0, st[2:0]});
    ahb(1'b0, 8'h10, 32'h0);
    chk("unmapped read", 32'h0, st);
    for (int i = 0; i < 16; i++)
    begin
      wd[i] = 8'(rnd());
      ahb(1'b1, radio_spi_pkg::TXDATA_ADDR, {24'h0, wd[i]});
    end
    ahb(1'b0, radio_spi_pkg::STATUS_ADDR, 32'h0);
    chk("tx full", 32'h1, {31'h0, st[radio_spi_pkg::ST_TXFULL_BIT]});
    state <= 3'(rnd());
    run(8'h40, 6'h10);
    chk("status byte", {24'h0, stat(state, 0)}, {24'h0, st[15:8]});
    chk("write count", 32'd16, 32'(cq.size()));
    for (int i = 0; i < 16; i++)
      chk("config write", {18'h0, 6'(i), wd[i]}, {18'h0, cq.pop_front()});
    run(8'hc0, 6'h10);
    for (int i = 0; i < 16; i++)
    begin
      rd();
      chk("config read", {24'h0, wd[i]}, st);
    end
    rd();
    chk("empty pop", 32'h0, st);
    run(8'ha0, 6'h01);
    rd();
    chk("default value", {24'h0, radio_spi_pkg::CFG_RESET}, st);
    // strobe while the oscillator is off: the controller must hold off
    osc_off <= 1'b1;
    ahb(1'b1, radio_spi_pkg::CTRL_ADDR, 32'h0001_0030);
    repeat (60) @(posedge mclk_i);
    chk("ready held off", 32'h1, {31'h0, lnk.miso_line});
    osc_off <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      run(8'h30 + 8'(so[i]), 6'h00);
      chk("wire header", {24'h0, 8'h30 + 8'(so[i])}, {24'h0, sh});
      chk("strobe", 32'(6'h30 + 6'(so[i])), {26'h0, sq.pop_front()});
    end
    chk("stray write", 32'h0, 32'(cq.size()));
    for (int i = 0; i < 64; i++)
    begin
      b = 8'(rnd());
      rx_data <= b;
      rq.push_back(b);
      rx_valid <= 1'b1;
      @(posedge mclk_i iff rx_ready === 1'b1);
    end
    rx_valid <= 1'b0;
    @(posedge mclk_i);
    chk("rx full", 32'h0, {31'h0, rx_ready});
    run(8'hfb, 6'h01);
    chk("status saturates", {24'h0, stat(state, 64)}, {24'h0, st[15:8]});
    rd();
    chk("fifo count", 32'd64, st);
    // the port fetches a byte ahead, so a burst of 15 empties 16
    for (int j = 0; j < 4; j++)
    begin
      run(8'hff, 6'h0f);
      for (int i = 0; i < 15; i++)
      begin
        rd();
        chk("rx byte", {24'h0, rq.pop_front()}, st);
      end
      void'(rq.pop_front());
    end
    chk("rx room", 32'h1, {31'h0, rx_ready});
    xfer(12);
    chk("aborted write", 32'h0, 32'(nb));
    xfer(16);
    chk("whole write", 32'h1, 32'(nb));
    conclude();
  end

  // watchdog sized well above the expected run
  initial
  begin
    #1500000;
    fail_count++;
    conclude();
  end
endmodule
